// *** inc/dcff_pkg.sv ***
// shared constants and types of the dual-clock fifo flag controller
package dcff_pkg;

    // ==========================================================
    // storage geometry
    localparam int unsigned DCFF_DATA_W = 36;
    localparam int unsigned DCFF_AW     = 19;
    localparam int unsigned DCFF_LVL_W  = 20;
    localparam int unsigned DCFF_WORDS  = 524288;

    // the almost-full threshold counts against these depths
    localparam logic [19:0] DCFF_DEPTH_STD  = 20'h80000;
    localparam logic [19:0] DCFF_DEPTH_FALL_THROUGH_MODE = 20'h80001;

    // ==========================================================
    // offset register reset values
    localparam logic [19:0] DCFF_AE_RST = 20'h0007F;
    localparam logic [19:0] DCFF_AF_RST = 20'h0007F;

    // ==========================================================
    // apb register map
    localparam int unsigned DCFF_PADDR_W    = 8;
    localparam logic [7:0]  DCFF_REG_CTRL   = 8'h00;
    localparam logic [7:0]  DCFF_REG_AE     = 8'h04;
    localparam logic [7:0]  DCFF_REG_AF     = 8'h08;
    localparam logic [7:0]  DCFF_REG_STATUS = 8'h0C;
    localparam logic [7:0]  DCFF_REG_LEVEL  = 8'h10;
    localparam int unsigned DCFF_CTRL_ASYNC_RD = 0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic                   wr_clk;
        logic                   rd_clk;
        logic                   wen_n;
        logic                   wcs_n;
        logic                   ren_n;
        logic                   rcs_n;
        logic                   rt_n;
        logic                   mark;
        logic                   flag_timing_select;
        logic                   fall_through_mode;
        logic [DCFF_DATA_W-1:0] data;
    } dcff_pins_s;

    typedef struct packed {
        logic fall_through_mode;
        logic sync_flags;
    } dcff_cfg_s;

    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic space_n;
        logic valid_n;
        logic ae_n;
        logic af_n;
    } dcff_flags_s;

endpackage

// *** logic/dcff_sync.sv ***
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none

module dcff_sync
#(
    parameter int unsigned W = 1
)
(
    input  wire logic         i_core_clk,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);

    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk)
    begin
        meta <= i_d;
        o_q  <= meta;
    end

endmodule

`default_nettype wire

// *** logic/dcff_ctrl.sv ***
// dual-clock fifo flag controller with apb register access
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dcff_ctrl
(
    input  wire logic                            i_core_clk,
    input  wire logic                            i_resetn,
    input  wire logic                            i_wr_clk,
    input  wire logic                            i_write_en_n,
    input  wire logic                            i_write_port_select_n,
    input  wire logic [dcff_pkg::DCFF_DATA_W-1:0] i_data,
    input  wire logic                            i_rd_clk,
    input  wire logic                            i_read_en_n,
    input  wire logic                            i_read_port_select_n,
    input  wire logic                            i_retransmit_n,
    input  wire logic                            i_mark,
    input  wire logic                            i_flag_timing_select,
    input  wire logic                            i_fall_through_mode,
    output var  dcff_pkg::dcff_flags_s           o_flags,
    output var  logic [dcff_pkg::DCFF_DATA_W-1:0] o_data,
    input  wire logic                            i_psel,
    input  wire logic                            i_penable,
    input  wire logic                            i_pwrite,
    input  wire logic [dcff_pkg::DCFF_PADDR_W-1:0] i_paddr,
    input  wire logic [31:0]                     i_pwdata,
    output var  logic [31:0]                     o_prdata,
    output var  logic                            o_pready,
    output var  logic                            o_pslverr
);

    localparam int unsigned LW = dcff_pkg::DCFF_LVL_W;
    localparam int unsigned AW = dcff_pkg::DCFF_AW;

    // ==========================================================
    // pin synchronisation and edge detection
    dcff_pkg::dcff_pins_s pins_raw;
    dcff_pkg::dcff_pins_s pins;
    logic                 prev_wclk;
    logic                 prev_rclk;
    logic                 prev_ren_n;

    assign pins_raw = {i_wr_clk, i_rd_clk, i_write_en_n,
                       i_write_port_select_n, i_read_en_n,
                       i_read_port_select_n, i_retransmit_n, i_mark,
                       i_flag_timing_select, i_fall_through_mode, i_data};

    dcff_sync #(.W($bits(dcff_pkg::dcff_pins_s))) u_sync
    (
        .i_core_clk (i_core_clk),
        .i_d        (pins_raw),
        .o_q        (pins)
    );

    always_ff @(posedge i_core_clk)
    begin
        prev_wclk  <= pins.wr_clk;
        prev_rclk  <= pins.rd_clk;
        prev_ren_n <= pins.ren_n;
    end

    // ==========================================================
    // state
    dcff_pkg::dcff_cfg_s cfg;
    logic                ctrl_async_rd;
    logic [LW-1:0]       ae_off;
    logic [LW-1:0]       af_off;
    logic [LW-1:0]       wptr;
    logic [LW-1:0]       rptr;
    logic [LW-1:0]       mark_ptr;
    logic                mark_set;
    logic                rt_busy;
    logic                rd_avail;
    logic                out_valid;
    logic                full_q;
    logic [dcff_pkg::DCFF_DATA_W-1:0] mem [dcff_pkg::DCFF_WORDS];

    // ==========================================================
    // event decode
    wire wr_edge     = pins.wr_clk & ~prev_wclk;
    wire rd_edge     = pins.rd_clk & ~prev_rclk;
    wire ren_fall    = prev_ren_n & ~pins.ren_n;
    wire async_rd_on = ctrl_async_rd & ~cfg.fall_through_mode;
    wire rd_evt      = async_rd_on ? ren_fall : rd_edge;
    wire rd_sel      = ~pins.ren_n & ~pins.rcs_n;
    wire rt_go       = rd_evt & ~pins.rt_n & mark_set;

    wire [LW-1:0] mem_lvl = wptr - rptr;
    wire [LW-1:0] level   = mem_lvl + LW'(out_valid);
    wire [LW-1:0] depth   = cfg.fall_through_mode ? dcff_pkg::DCFF_DEPTH_FALL_THROUGH_MODE
                                     : dcff_pkg::DCFF_DEPTH_STD;
    wire [LW-1:0] mark_used = wptr - mark_ptr;

    // writes stop at the marked location
    wire wr_full  = (mem_lvl == dcff_pkg::DCFF_DEPTH_STD) |
                    (mark_set & (mark_used == dcff_pkg::DCFF_DEPTH_STD));
    wire do_write = wr_edge & ~pins.wen_n & ~pins.wcs_n & ~wr_full;

    wire rd_ok    = rd_avail & ~rt_busy & ~rt_go;
    wire std_pop  = ~cfg.fall_through_mode & rd_evt & rd_sel & rd_ok;
    // first word loads regardless of enables
    wire fw_load  = cfg.fall_through_mode & rd_edge & rd_ok
                    & (~out_valid | rd_sel);
    wire pop      = std_pop | fw_load;
    wire fw_drain = cfg.fall_through_mode & rd_edge & out_valid & rd_sel
                    & ~fw_load & ~rt_go;

    wire [LW-1:0] next_wptr = wptr + LW'(do_write);
    wire [LW-1:0] next_rptr = rt_go ? mark_ptr : rptr + LW'(pop);

    // opposite pointer taken as last seen: one edge of latency
    wire full_after = ((next_wptr - rptr) == dcff_pkg::DCFF_DEPTH_STD) |
                      (mark_set &
                       ((next_wptr - mark_ptr) == dcff_pkg::DCFF_DEPTH_STD));
    wire avail_after = (wptr - next_rptr) != '0;

    wire next_full  = wr_edge ? full_after : full_q;
    wire next_avail = rt_go ? 1'b0 : (rd_evt ? avail_after : rd_avail);
    wire next_out_valid = rt_go ? 1'b0 : (fw_load ? 1'b1 :
                          (fw_drain ? 1'b0 : out_valid));

    // thresholds judged on the fill left by this event
    wire [LW-1:0] level_next = (next_wptr - next_rptr)
                               + LW'(next_out_valid);
    wire ae_hit = level_next <= ae_off;
    wire af_hit = level_next >= (depth - af_off);

    // sync: each flag moves on its own side; async: set/clear split
    wire next_ae_n = cfg.sync_flags ?
                     (rd_evt ? ~ae_hit : o_flags.ae_n) :
                     ((rd_evt & ae_hit) ? 1'b0 :
                     ((wr_edge & ~ae_hit) ? 1'b1 : o_flags.ae_n));
    wire next_af_n = cfg.sync_flags ?
                     (wr_edge ? ~af_hit : o_flags.af_n) :
                     ((wr_edge & af_hit) ? 1'b0 :
                     ((rd_evt & ~af_hit) ? 1'b1 : o_flags.af_n));

    // ==========================================================
    // storage
    always_ff @(posedge i_core_clk)
    begin
        if (do_write)
            mem[wptr[AW-1:0]] <= pins.data;
    end

    // ==========================================================
    // pointers, mark and retransmit
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            cfg      <= '{fall_through_mode: pins.fall_through_mode, sync_flags: pins.flag_timing_select};
            wptr     <= '0;
            rptr     <= '0;
            mark_ptr <= '0;
            mark_set <= 1'b0;
            rt_busy  <= 1'b0;
        end
        else
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            if (rd_evt)
                mark_set <= pins.mark;
            if (rd_evt & pins.mark & ~mark_set)
                mark_ptr <= rptr;
            // busy for one read edge after retransmit
            if (rt_go)
                rt_busy <= 1'b1;
            else if (rd_evt)
                rt_busy <= 1'b0;
        end
    end

    // ==========================================================
    // flags and output data
    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            rd_avail  <= 1'b0;
            out_valid <= 1'b0;
            full_q    <= 1'b0;
            o_flags   <= '{empty_n: 1'b0, full_n: 1'b1, space_n: 1'b1,
                           valid_n: 1'b1, ae_n: 1'b0, af_n: 1'b1};
            o_data    <= '0;
        end
        else
        begin
            rd_avail        <= next_avail;
            out_valid       <= next_out_valid;
            full_q          <= next_full;
            o_flags.empty_n <= ~cfg.fall_through_mode & next_avail;
            o_flags.valid_n <= ~(cfg.fall_through_mode & next_out_valid);
            o_flags.full_n  <= cfg.fall_through_mode | ~next_full;
            o_flags.space_n <= ~cfg.fall_through_mode | next_full;
            o_flags.ae_n    <= next_ae_n;
            o_flags.af_n    <= next_af_n;
            if (pop)
                o_data <= mem[rptr[AW-1:0]];
        end
    end

    // ==========================================================
    // apb slave, zero wait states
    wire setup  = i_psel & ~i_penable;
    wire acc_wr = i_psel & i_penable & o_pready & i_pwrite;
    wire hit_ctrl = i_paddr == dcff_pkg::DCFF_REG_CTRL;
    wire hit_ae   = i_paddr == dcff_pkg::DCFF_REG_AE;
    wire hit_af   = i_paddr == dcff_pkg::DCFF_REG_AF;
    wire hit_stat = i_paddr == dcff_pkg::DCFF_REG_STATUS;
    wire hit_lvl  = i_paddr == dcff_pkg::DCFF_REG_LEVEL;
    wire mapped   = hit_ctrl | hit_ae | hit_af | hit_stat | hit_lvl;
    wire ro_write = i_pwrite & (hit_stat | hit_lvl);
    wire [31:0] rd_mux =
        hit_ctrl ? 32'(ctrl_async_rd) :
        hit_ae   ? 32'(ae_off) :
        hit_af   ? 32'(af_off) :
        hit_stat ? 32'({mark_set, rt_busy, cfg, o_flags}) :
        hit_lvl  ? 32'(level) : 32'h0000_0000;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            o_pready      <= 1'b0;
            o_pslverr     <= 1'b0;
            o_prdata      <= '0;
            ctrl_async_rd <= 1'b0;
            ae_off        <= dcff_pkg::DCFF_AE_RST;
            af_off        <= dcff_pkg::DCFF_AF_RST;
        end
        else
        begin
            o_pready  <= setup;
            o_pslverr <= setup & (~mapped | ro_write);
            o_prdata  <= (setup & ~i_pwrite) ? rd_mux : '0;
            if (acc_wr & hit_ctrl)
                ctrl_async_rd <= i_pwdata[dcff_pkg::DCFF_CTRL_ASYNC_RD];
            if (acc_wr & hit_ae)
                ae_off <= i_pwdata[LW-1:0];
            if (acc_wr & hit_af)
                af_off <= i_pwdata[LW-1:0];
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_rt_start;
        rt_go;
    endsequence

    sequence s_rt_done_std;
        rd_evt & ~rt_go & (mem_lvl != '0) ##1 o_flags.empty_n;
    endsequence

    property p_full_moves_on_write;
        $past(i_resetn) & $changed(o_flags.full_n) |-> $past(wr_edge);
    endproperty
    a_full_moves_on_write: assert property (p_full_moves_on_write)
        else $error("full flag moved without write edge");

    property p_empty_moves_on_read;
        $past(i_resetn) & ~cfg.fall_through_mode & $changed(o_flags.empty_n)
            |-> $past(rd_evt);
    endproperty
    a_empty_moves_on_read: assert property (p_empty_moves_on_read)
        else $error("empty flag moved without read event");

    property p_first_word_std;
        ~cfg.fall_through_mode & ~o_flags.empty_n & ~rt_busy & rd_evt & ~rt_go
            & (wptr != rptr) |=> o_flags.empty_n;
    endproperty
    a_first_word_std: assert property (p_first_word_std)
        else $error("standard first word not flagged after read edge");

    property p_first_word_fall_through_mode;
        cfg.fall_through_mode & ~out_valid & rd_edge & rd_avail & ~rt_busy & ~rt_go
            |=> ~o_flags.valid_n;
    endproperty
    a_first_word_fall_through_mode: assert property (p_first_word_fall_through_mode)
        else $error("first word did not fall through");

    property p_space_fall_through_mode;
        cfg.fall_through_mode & wr_edge & ~full_after |=> ~o_flags.space_n;
    endproperty
    a_space_fall_through_mode: assert property (p_space_fall_through_mode)
        else $error("input space not shown after write edge");

    property p_af_sync;
        $past(i_resetn) & cfg.sync_flags & $changed(o_flags.af_n)
            |-> $past(wr_edge);
    endproperty
    a_af_sync: assert property (p_af_sync)
        else $error("sync almost-full moved off write edge");

    property p_ae_async;
        $past(i_resetn) & ~cfg.sync_flags & $fell(o_flags.ae_n)
            |-> $past(rd_evt);
    endproperty
    a_ae_async: assert property (p_ae_async)
        else $error("async almost-empty fell without read event");

    property p_af_async;
        $past(i_resetn) & ~cfg.sync_flags & $rose(o_flags.af_n)
            |-> $past(rd_evt);
    endproperty
    a_af_async: assert property (p_af_async)
        else $error("async almost-full rose without read event");

    property p_rt_std;
        ~cfg.fall_through_mode & s_rt_start |=> ~o_flags.empty_n ##0 s_rt_done_std
            or ~o_flags.empty_n ##0 ~(rd_evt & ~rt_go & (mem_lvl != '0));
    endproperty
    a_rt_std: assert property (p_rt_std)
        else $error("retransmit setup did not end with empty high");

    property p_mark_guard;
        mark_set |-> mark_used <= dcff_pkg::DCFF_DEPTH_STD;
    endproperty
    a_mark_guard: assert property (p_mark_guard)
        else $error("write pointer passed the mark");

    property p_async_rd_std_only;
        cfg.fall_through_mode & rd_evt |-> rd_edge;
    endproperty
    a_async_rd_std_only: assert property (p_async_rd_std_only)
        else $error("async read port used in fall-through mode");

endmodule

`default_nettype wire

// *** dv/dcff_pins_model.sv ***
// writer and reader logic driving the fifo pin side
`timescale 1ns/1ps
`default_nettype none

module dcff_pins_model
(
    input  wire logic                             i_core_clk,
    output var  logic                             o_wr_clk,
    output var  logic                             o_write_en_n,
    output var  logic [dcff_pkg::DCFF_DATA_W-1:0] o_data,
    output var  logic                             o_rd_clk,
    output var  logic                             o_read_en_n,
    output var  logic                             o_read_port_select_n,
    output var  logic                             o_retransmit_n
);
    // ==========================================================
    // idle levels
    initial
    begin
        o_wr_clk             = 1'b0;
        o_write_en_n         = 1'b1;
        o_data               = 36'h0;
        o_rd_clk             = 1'b0;
        o_read_en_n          = 1'b1;
        o_read_port_select_n = 1'b0;
        o_retransmit_n       = 1'b1;
    end

    // ==========================================================
    // one pin clock period: four core cycles high, eight low
    task automatic wr(input logic en_n, input logic [35:0] d);
        @(posedge i_core_clk);
        o_write_en_n <= en_n;
        o_data       <= d;
        repeat (4) @(posedge i_core_clk);
        o_wr_clk <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_wr_clk     <= 1'b0;
        o_write_en_n <= 1'b1;
        o_data       <= ~d;
        repeat (3) @(posedge i_core_clk);
    endtask

    // enable raised again at the falling edge
    task automatic rd(input logic en_n, input logic cs_n);
        @(posedge i_core_clk);
        o_read_en_n          <= en_n;
        o_read_port_select_n <= cs_n;
        repeat (4) @(posedge i_core_clk);
        o_rd_clk <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_rd_clk    <= 1'b0;
        o_read_en_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
    endtask
endmodule

`default_nettype wire

// *** dv/dual_clock_fifo_flag_control_test.sv ***
// self-checking bench of the fifo flag controller
`timescale 1ns/1ps
`default_nettype none

module dual_clock_fifo_flag_control_test;
    localparam logic [31:0] M2 = {12'h000,
                                  dcff_pkg::DCFF_DEPTH_STD - 20'h00002};
    localparam logic [7:0]  AE = dcff_pkg::DCFF_REG_AE;
    localparam logic [7:0]  AF = dcff_pkg::DCFF_REG_AF;

    logic                  core_clk = 1'b0;
    logic                  resetn;
    logic                  fall_through_mode;
    logic                  flag_timing_select;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  wr_clk;
    logic                  wen_n;
    logic [35:0]           wdata;
    logic                  rd_clk;
    logic                  ren_n;
    logic                  rcs_n;
    logic                  rt_n;
    logic [35:0]           q;
    dcff_pkg::dcff_flags_s flags;
    int                    fails = 0;
    int                    n_tests = 0;

    always #2.5 core_clk = ~core_clk;

    dcff_ctrl dcff_ctrl_i
    (
        .i_core_clk            (core_clk),
        .i_resetn              (resetn),
        .i_wr_clk              (wr_clk),
        .i_write_en_n          (wen_n),
        .i_write_port_select_n (1'b0),
        .i_data                (wdata),
        .i_rd_clk              (rd_clk),
        .i_read_en_n           (ren_n),
        .i_read_port_select_n  (rcs_n),
        .i_retransmit_n        (rt_n),
        .i_mark                (1'b0),
        .i_flag_timing_select  (flag_timing_select),
        .i_fall_through_mode   (fall_through_mode),
        .o_flags               (flags),
        .o_data                (q),
        .i_psel                (psel),
        .i_penable             (penable),
        .i_pwrite              (pwrite),
        .i_paddr               (paddr),
        .i_pwdata              (pwdata),
        .o_prdata              (prdata),
        .o_pready              (pready),
        .o_pslverr             (pslverr)
    );

    dcff_pins_model dcff_pins_model_i
    (
        .i_core_clk           (core_clk),
        .o_wr_clk             (wr_clk),
        .o_write_en_n         (wen_n),
        .o_data               (wdata),
        .o_rd_clk             (rd_clk),
        .o_read_en_n          (ren_n),
        .o_read_port_select_n (rcs_n),
        .o_retransmit_n       (rt_n)
    );

    // ==========================================================
    // compare and report
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_val(input string nm, input logic [35:0] e,
                           input logic [35:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // apb master and reset
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic ee,
                       input logic [31:0] ed);
        int k;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
        begin
            fails++;
            $display("MISMATCH pready expected 1 seen %b", pready);
            tally_and_finish();
        end
        else
        begin
            chk_bit("pslverr", ee, pslverr);
            if (!wr && !ee)
                chk_val("prdata", {4'h0, ed}, {4'h0, prdata});
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rst(input logic ff, input logic pf);
        @(posedge core_clk);
        resetn <= 1'b0;
        fall_through_mode   <= ff;
        flag_timing_select    <= pf;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask

    // ==========================================================
    // scenarios
    task automatic s_regs();
        rst(1'b0, 1'b1);
        chk_val("flags", 36'h1D, {30'h0, flags});
        apb(1'b0, AE, 32'h0, 1'b0, 32'h7F);
        apb(1'b0, AF, 32'h0, 1'b0, 32'h7F);
        apb(1'b0, 8'h14, 32'h0, 1'b1, 32'h0);
        apb(1'b1, dcff_pkg::DCFF_REG_STATUS, 32'h0, 1'b1, 32'h0);
    endtask

    task automatic s_std();
        apb(1'b1, AE, 32'h1, 1'b0, 32'h0);
        apb(1'b0, AE, 32'h0, 1'b0, 32'h1);
        dcff_pins_model_i.wr(1'b0, 36'h123456789);
        chk_bit("empty_n", 1'b0, flags.empty_n);
        dcff_pins_model_i.rd(1'b1, 1'b0);
        chk_bit("empty_n", 1'b1, flags.empty_n);
        dcff_pins_model_i.wr(1'b0, 36'hABCDEF012);
        dcff_pins_model_i.rd(1'b1, 1'b0);
        chk_bit("ae_n", 1'b1, flags.ae_n);
        dcff_pins_model_i.rd(1'b0, 1'b0);
        chk_val("q", 36'h123456789, q);
        dcff_pins_model_i.rd(1'b0, 1'b0);
        chk_val("q", 36'hABCDEF012, q);
        chk_bit("empty_n", 1'b0, flags.empty_n);
    endtask

    task automatic s_af();
        apb(1'b1, AF, M2, 1'b0, 32'h0);
        dcff_pins_model_i.wr(1'b0, 36'h000000001);
        chk_bit("af_n", 1'b1, flags.af_n);
        dcff_pins_model_i.wr(1'b0, 36'h000000002);
        chk_bit("af_n", 1'b0, flags.af_n);
        dcff_pins_model_i.rd(1'b1, 1'b0);
        dcff_pins_model_i.rd(1'b0, 1'b0);
        chk_bit("af_n", 1'b0, flags.af_n);
        dcff_pins_model_i.wr(1'b1, 36'h000000003);
        chk_bit("af_n", 1'b1, flags.af_n);
    endtask

    task automatic s_async();
        rst(1'b0, 1'b0);
        apb(1'b1, AE, 32'h1, 1'b0, 32'h0);
        apb(1'b1, AF, M2, 1'b0, 32'h0);
        dcff_pins_model_i.wr(1'b0, 36'h0000000AA);
        dcff_pins_model_i.wr(1'b0, 36'h000000055);
        chk_bit("ae_n", 1'b1, flags.ae_n);
        chk_bit("af_n", 1'b0, flags.af_n);
        dcff_pins_model_i.rd(1'b1, 1'b0);
        chk_bit("empty_n", 1'b1, flags.empty_n);
        dcff_pins_model_i.rd(1'b0, 1'b0);
        chk_bit("ae_n", 1'b0, flags.ae_n);
        chk_bit("af_n", 1'b1, flags.af_n);
        chk_val("q", 36'h0000000AA, q);
    endtask

    task automatic s_fall_through_mode();
        rst(1'b1, 1'b1);
        chk_val("flags", 36'h15, {30'h0, flags});
        dcff_pins_model_i.wr(1'b0, 36'h0C0C0C0C0);
        dcff_pins_model_i.rd(1'b1, 1'b1);
        chk_bit("valid_n", 1'b1, flags.valid_n);
        dcff_pins_model_i.rd(1'b1, 1'b1);
        chk_bit("valid_n", 1'b0, flags.valid_n);
        chk_val("q", 36'h0C0C0C0C0, q);
        dcff_pins_model_i.wr(1'b0, 36'h0D0D0D0D0);
        dcff_pins_model_i.rd(1'b0, 1'b1);
        chk_val("q", 36'h0C0C0C0C0, q);
        dcff_pins_model_i.rd(1'b1, 1'b0);
        chk_val("q", 36'h0C0C0C0C0, q);
        dcff_pins_model_i.rd(1'b0, 1'b0);
        chk_val("q", 36'h0D0D0D0D0, q);
        dcff_pins_model_i.rd(1'b0, 1'b0);
        chk_bit("valid_n", 1'b1, flags.valid_n);
    endtask

    initial
    begin
        resetn  = 1'b0;
        fall_through_mode    = 1'b0;
        flag_timing_select     = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        s_regs();
        s_std();
        s_af();
        s_async();
        s_fall_through_mode();
        tally_and_finish();
    end
endmodule

`default_nettype wire
